// [rtl/pig_gate.sv]
/*
 * Prefix tracking, flag-write gating, register bank redirection and the
 * hardware interrupt entry sequencer of the CPU.
 * Assumes the decode path, the memory port and the interrupt controller all
 * run on core_clk, so no input is synchronised.
 */
`timescale 1ns/10ps
module pig_gate (
	// Clock, reset and clock enable.
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	input  wire logic                    ce,
	// Decode path.
	input  wire pig_pkg::pig_retire_t    retire,
	input  wire pig_pkg::pig_cls_t       exec_cls,
	input  wire logic [4:0]              bank_pointer,
	input  wire pig_pkg::pig_cpu_state_t cpu_state,
	output logic [23:0]                  reg_bank_base,
	output logic [7:0]                   ccr_write_mask,
	output logic                         shared_bank_prefix,
	output logic                         flag_freeze_prefix,
	output logic [1:0]                   bank_sel_code,
	output logic                         bank_sel_valid,
	output logic                         core_hold,
	// Interrupt controller.
	input  wire pig_pkg::pig_irq_t       irq,
	output logic                         irq_ack,
	// System stack and vector memory port.
	output pig_pkg::pig_stack_wr_t       stack_wr,
	input  wire logic                    stack_wr_ready,
	output logic                         vec_rd_valid,
	output logic [23:0]                  vec_rd_addr,
	input  wire logic                    vec_rd_ready,
	input  wire logic [23:0]             vec_rd_data,
	output pig_pkg::pig_branch_t         branch
);
	import pig_pkg::*;

	typedef struct packed {
		pig_fsm_t       fsm;
		logic           shared_bank;
		logic           flag_freeze;
		logic           bank_valid;
		logic [1:0]     bank_code;
		logic           ack;
		logic [2:0]     level;
		logic [23:0]    vec_addr;
		pig_cpu_state_t snap;
		pig_stack_wr_t  wr;
		pig_branch_t    br;
	} pig_state_t;

	pig_state_t st_r;
	pig_state_t st_nxt;
	logic       blocking;
	logic       irq_ok;
	logic       accept;

	////////////////////////////////////////////////////////////////////////////
	// Decode helpers.

	// Instructions during which a hardware request is not even looked at.
	function automatic logic is_blocking(input pig_cls_t c);
		is_blocking = (c == PIG_CLS_SHARED_BANK) || (c == PIG_CLS_FLAG_FREEZE) ||
			(c == PIG_CLS_BANK_SEL) || (c == PIG_CLS_CCR_ANDOR) ||
			(c == PIG_CLS_POP_STATUS) || (c == PIG_CLS_ILM_SET);
	endfunction

	// Instructions that rewrite the condition flags even under flag freeze.
	function automatic logic is_ccr_exempt(input pig_cls_t c);
		is_ccr_exempt = (c == PIG_CLS_CCR_ANDOR) || (c == PIG_CLS_POP_STATUS) ||
			(c == PIG_CLS_SOFT_INT) || (c == PIG_CLS_FAR_SOFT_INT) ||
			(c == PIG_CLS_INT_RETURN) || (c == PIG_CLS_CTX_JUMP);
	endfunction

	// Word pushed and its size, by position in the save sequence.
	function automatic logic [31:0] slot_data(input pig_cpu_state_t s, input logic [2:0] i);
		case (i)
			3'h0:    slot_data = s.acc;
			3'h1:    slot_data = {24'h000000, s.direct_page_reg};
			3'h2:    slot_data = {24'h000000, s.extra_data_bank};
			3'h3:    slot_data = {24'h000000, s.data_bank_reg};
			3'h4:    slot_data = {24'h000000, s.program_bank_reg};
			3'h5:    slot_data = {16'h0000, s.pc};
			default: slot_data = {16'h0000, s.processor_status};
		endcase
	endfunction

	function automatic logic [2:0] slot_bytes(input logic [2:0] i);
		case (i)
			3'h0:          slot_bytes = PIG_BYTES_LONG;
			3'h5, 3'h6:    slot_bytes = PIG_BYTES_WORD;
			default:       slot_bytes = PIG_BYTES_BYTE;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Acceptance. A request is looked at only when a non-blocking instruction
	// retires, so a request seen under a blocking one simply waits.
	assign blocking = is_blocking(retire.cls);
	assign irq_ok   = irq.valid && cpu_state.processor_status[PIG_I_BIT] &&
		(irq.request_level < cpu_state.processor_status[PIG_ILM_MSB:PIG_ILM_LSB]);
	assign accept   = (st_r.fsm == PIG_ST_RUN) && retire.valid && !blocking && irq_ok;

	// Next state.
	always_comb begin
		st_nxt          = st_r;
		st_nxt.ack      = 1'b0;
		st_nxt.br.valid = 1'b0;
		if (retire.valid) begin
			unique case (retire.cls)
				PIG_CLS_SHARED_BANK: begin
					st_nxt.shared_bank = 1'b1;
				end
				PIG_CLS_FLAG_FREEZE: begin
					st_nxt.flag_freeze = 1'b1;
				end
				PIG_CLS_BANK_SEL: begin
					// A later bank prefix replaces an earlier one.
					st_nxt.bank_valid = 1'b1;
					st_nxt.bank_code  = retire.bank_code;
				end
				PIG_CLS_CCR_ANDOR, PIG_CLS_POP_STATUS, PIG_CLS_ILM_SET: begin
					// Pending prefixes ride over these to the next instruction.
					st_nxt.shared_bank = st_r.shared_bank;
				end
				default: begin
					st_nxt.shared_bank = 1'b0;
					st_nxt.flag_freeze = 1'b0;
					st_nxt.bank_valid  = 1'b0;
				end
			endcase
		end
		unique case (st_r.fsm)
			PIG_ST_RUN: begin
				if (accept) begin
					st_nxt.fsm      = PIG_ST_SAVE;
					st_nxt.ack      = 1'b1;
					st_nxt.level    = irq.request_level;
					st_nxt.vec_addr = PIG_VEC_TOP - (24'(irq.number) << PIG_VEC_SHIFT);
					st_nxt.snap     = cpu_state;
					st_nxt.wr.valid = 1'b1;
					st_nxt.wr.sel   = PIG_SAVE_FIRST;
					st_nxt.wr.bytes = slot_bytes(PIG_SAVE_FIRST);
					st_nxt.wr.data  = slot_data(cpu_state, PIG_SAVE_FIRST);
				end
			end
			PIG_ST_SAVE: begin
				if (stack_wr_ready) begin
					if (st_r.wr.sel == PIG_SAVE_LAST) begin
						st_nxt.wr.valid = 1'b0;
						st_nxt.fsm      = PIG_ST_VECTOR;
					end else begin
						st_nxt.wr.sel   = st_r.wr.sel + 3'h1;
						st_nxt.wr.bytes = slot_bytes(st_r.wr.sel + 3'h1);
						st_nxt.wr.data  = slot_data(st_r.snap, st_r.wr.sel + 3'h1);
					end
				end
			end
			PIG_ST_VECTOR: begin
				if (vec_rd_ready) begin
					// Three vector bytes: low two to the counter, top to the bank.
					st_nxt.fsm                 = PIG_ST_BRANCH;
					st_nxt.br.valid            = 1'b1;
					st_nxt.br.pc               = vec_rd_data[15:0];
					st_nxt.br.program_bank_reg = vec_rd_data[23:16];
					st_nxt.br.processor_status = st_r.snap.processor_status;
					st_nxt.br.processor_status[PIG_ILM_MSB:PIG_ILM_LSB] = st_r.level;
					st_nxt.br.processor_status[PIG_S_BIT] = 1'b1;
				end
			end
			PIG_ST_BRANCH: begin
				st_nxt.fsm = PIG_ST_RUN;
			end
		endcase
	end

	// Registers; the clock enable freezes everything.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_r <= '0;
		end else if (ce) begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs toward the execute stage.

	// Common bank overrides the pointer; otherwise banks are sixteen bytes apart.
	assign reg_bank_base = st_r.shared_bank ? PIG_BANK_COMMON_BASE :
		PIG_BANK_COMMON_BASE + (24'(bank_pointer) << PIG_BANK_SHIFT);
	// Only T, N, Z, V and C are masked; I, S and the exempt classes pass.
	assign ccr_write_mask = (st_r.flag_freeze && !is_ccr_exempt(exec_cls)) ?
		(PIG_CCR_ALL & ~PIG_FLAG_TNZVC) : PIG_CCR_ALL;
	assign shared_bank_prefix = st_r.shared_bank;
	assign flag_freeze_prefix = st_r.flag_freeze;
	assign bank_sel_valid     = st_r.bank_valid;
	assign bank_sel_code      = st_r.bank_code;
	// Fetch stalls for the whole entry so no instruction slips in.
	assign core_hold    = (st_r.fsm != PIG_ST_RUN);
	assign irq_ack      = st_r.ack;
	assign stack_wr     = st_r.wr;
	assign vec_rd_valid = (st_r.fsm == PIG_ST_VECTOR);
	assign vec_rd_addr  = st_r.vec_addr;
	assign branch       = st_r.br;

	////////////////////////////////////////////////////////////////////////////
	// Checks.

	// Byte count of the current save run, read only by the checks.
	logic [4:0] saved_bytes_r;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			saved_bytes_r <= 5'h00;
		end else if (ce && accept) begin
			saved_bytes_r <= 5'h00;
		end else if (ce && stack_wr.valid && stack_wr_ready) begin
			saved_bytes_r <= saved_bytes_r + {2'b00, stack_wr.bytes};
		end
	end

	sequence s_entry_start;
		ce && accept;
	endsequence

	sequence s_saves_done;
		ce && stack_wr.valid && stack_wr_ready && (stack_wr.sel == PIG_SAVE_LAST);
	endsequence

	a_common_bank_base: assert property (@(posedge core_clk) disable iff (!rst_b)
		shared_bank_prefix |-> (reg_bank_base == PIG_BANK_COMMON_BASE) &&
		(reg_bank_base + 24'h00000f == PIG_BANK_COMMON_LAST))
		else $error("shared bank prefix did not select the common bank");

	a_prefix_carry_over: assert property (@(posedge core_clk) disable iff (!rst_b)
		(ce && retire.valid && (retire.cls inside {PIG_CLS_CCR_ANDOR, PIG_CLS_POP_STATUS,
		PIG_CLS_ILM_SET}) && shared_bank_prefix) |=> shared_bank_prefix)
		else $error("prefix lost across a blocking instruction");

	a_freeze_mask: assert property (@(posedge core_clk) disable iff (!rst_b)
		(flag_freeze_prefix && (exec_cls == PIG_CLS_NORMAL)) |->
		((ccr_write_mask & PIG_FLAG_TNZVC) == 8'h00))
		else $error("flag freeze left arithmetic flags writable");

	a_freeze_exempt: assert property (@(posedge core_clk) disable iff (!rst_b)
		(flag_freeze_prefix && is_ccr_exempt(exec_cls)) |-> (ccr_write_mask == PIG_CCR_ALL))
		else $error("exempt instruction lost its flag write");

	a_no_blocked_accept: assert property (@(posedge core_clk) disable iff (!rst_b)
		(ce && retire.valid && is_blocking(retire.cls)) |=> !irq_ack)
		else $error("interrupt taken after a blocking instruction");

	a_accept_cond: assert property (@(posedge core_clk) disable iff (!rst_b)
		(ce && irq_ok && retire.valid && !blocking && !core_hold) |=> irq_ack)
		else $error("valid request not accepted");

	a_level_gate: assert property (@(posedge core_clk) disable iff (!rst_b)
		$rose(irq_ack) |-> $past(irq.valid) && $past(cpu_state.processor_status[PIG_I_BIT]) &&
		($past(irq.request_level) < $past(cpu_state.processor_status[PIG_ILM_MSB:PIG_ILM_LSB])))
		else $error("interrupt accepted while disabled or masked");

	a_save_order: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_entry_start |=> stack_wr.valid && (stack_wr.sel == PIG_SAVE_FIRST) &&
		(stack_wr.data == $past(cpu_state.acc)))
		else $error("save sequence did not open with the accumulator");

	a_twelve_bytes: assert property (@(posedge core_clk) disable iff (!rst_b)
		s_saves_done |=> (saved_bytes_r == PIG_SAVE_TOTAL))
		else $error("entry did not save twelve bytes");

	a_branch_status: assert property (@(posedge core_clk) disable iff (!rst_b)
		branch.valid |-> (branch.processor_status[PIG_ILM_MSB:PIG_ILM_LSB] == st_r.level) &&
		branch.processor_status[PIG_S_BIT])
		else $error("branch status lacks new mask or stack select");

	a_vector_branch: assert property (@(posedge core_clk) disable iff (!rst_b)
		(ce && vec_rd_valid && vec_rd_ready) |=> branch.valid &&
		({branch.program_bank_reg, branch.pc} == $past(vec_rd_data)))
		else $error("branch target differs from vector");

	a_prefix_cleared: assert property (@(posedge core_clk) disable iff (!rst_b)
		(ce && retire.valid && (retire.cls == PIG_CLS_NORMAL)) |=>
		!shared_bank_prefix && !flag_freeze_prefix && !bank_sel_valid)
		else $error("prefix not cleared after use");

endmodule

// [rtl/pig_pkg.sv]
/*
 * Shared types and constants for the prefix and interrupt gating block.
 * Assumes one CPU clock domain; every field below is produced or read by
 * logic on that clock.
 */
package pig_pkg;

	// Instruction classes as the decode path reports them.
	typedef enum logic [3:0] {
		PIG_CLS_NORMAL,
		PIG_CLS_SHARED_BANK,
		PIG_CLS_FLAG_FREEZE,
		PIG_CLS_BANK_SEL,
		PIG_CLS_CCR_ANDOR,
		PIG_CLS_POP_STATUS,
		PIG_CLS_ILM_SET,
		PIG_CLS_SOFT_INT,
		PIG_CLS_FAR_SOFT_INT,
		PIG_CLS_INT_RETURN,
		PIG_CLS_CTX_JUMP,
		PIG_CLS_STRING
	} pig_cls_t;

	// Sequencer states of the interrupt entry.
	typedef enum logic [1:0] {
		PIG_ST_RUN,
		PIG_ST_SAVE,
		PIG_ST_VECTOR,
		PIG_ST_BRANCH
	} pig_fsm_t;

	// One-cycle report that an instruction has finished executing.
	typedef struct packed {
		logic     valid;
		pig_cls_t cls;
		logic [1:0] bank_code;
	} pig_retire_t;

	// Request handed over by the interrupt controller.
	typedef struct packed {
		logic       valid;
		logic [2:0] request_level;
		logic [7:0] number;
	} pig_irq_t;

	// Architectural state that interrupt entry saves.
	typedef struct packed {
		logic [31:0] acc;
		logic [7:0]  direct_page_reg;
		logic [7:0]  extra_data_bank;
		logic [7:0]  data_bank_reg;
		logic [7:0]  program_bank_reg;
		logic [15:0] pc;
		logic [15:0] processor_status;
	} pig_cpu_state_t;

	// System stack write request.
	typedef struct packed {
		logic        valid;
		logic [2:0]  sel;
		logic [2:0]  bytes;
		logic [31:0] data;
	} pig_stack_wr_t;

	// Branch to the handler with the new processor status.
	typedef struct packed {
		logic        valid;
		logic [15:0] pc;
		logic [7:0]  program_bank_reg;
		logic [15:0] processor_status;
	} pig_branch_t;

	// Register bank placement.
	localparam logic [23:0] PIG_BANK_COMMON_BASE = 24'h000180;
	localparam logic [23:0] PIG_BANK_COMMON_LAST = 24'h00018f;
	localparam int          PIG_BANK_SHIFT       = 4;

	// Processor status layout.
	localparam int PIG_ILM_MSB = 15;
	localparam int PIG_ILM_LSB = 13;
	localparam int PIG_I_BIT   = 6;
	localparam int PIG_S_BIT   = 5;
	localparam logic [7:0] PIG_CCR_ALL    = 8'h7f;
	localparam logic [7:0] PIG_FLAG_TNZVC = 8'h1f;

	// Vector table: entry n sits at the top address minus four times n.
	localparam logic [23:0] PIG_VEC_TOP   = 24'hfffffc;
	localparam int          PIG_VEC_SHIFT = 2;

	// Save sequence: seven items, twelve bytes in all.
	localparam logic [2:0] PIG_SAVE_FIRST = 3'h0;
	localparam logic [2:0] PIG_SAVE_LAST  = 3'h6;
	localparam logic [4:0] PIG_SAVE_TOTAL = 5'h0c;
	localparam logic [2:0] PIG_BYTES_LONG = 3'h4;
	localparam logic [2:0] PIG_BYTES_WORD = 3'h2;
	localparam logic [2:0] PIG_BYTES_BYTE = 3'h1;

endpackage

// [tb/pig_irq_model.sv]
/*
 * Behavioural interrupt controller that feeds the gating block one request.
 * Assumes the bench pulses req_pulse for one cycle per request and that the
 * CPU acknowledges on irq_ack, all on core_clk.
 */
`timescale 1ns/10ps
module pig_irq_model (
	// Clock and reset.
	input  wire logic         core_clk,
	input  wire logic         rst_b,
	// Bench side.
	input  wire logic         req_pulse,
	input  wire logic [2:0]   req_level,
	input  wire logic [7:0]   req_number,
	// CPU side.
	input  wire logic         irq_ack,
	output pig_pkg::pig_irq_t irq
);
	import pig_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// A request stands until acknowledged; a withdrawn request shows inverted
	// fields, so a CPU that latches stale level or number is caught.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= '0;
		end else if (irq_ack) begin
			irq <= '{1'b0, ~irq.request_level, ~irq.number};
		end else if (req_pulse) begin
			irq <= '{1'b1, req_level, req_number};
		end
	end
endmodule

// [tb/prefix_and_interrupt_gating_test.sv]
/*
 * Self-checking bench for the prefix and interrupt gating block.
 * Assumes the design and the controller model share core_clk; the bench plays
 * the decode path and the stack and vector memory with random stalls.
 */
`timescale 1ns/10ps
module prefix_and_interrupt_gating_test;
	import pig_pkg::*;

	logic           core_clk, rst_b, ce, stack_wr_ready, vec_rd_ready, req_pulse;
	logic           shared_bank_prefix, flag_freeze_prefix, bank_sel_valid, core_hold;
	logic           irq_ack, vec_rd_valid;
	logic [1:0]     bank_sel_code;
	logic [2:0]     req_level;
	logic [4:0]     bank_pointer;
	logic [7:0]     ccr_write_mask, req_number, exp_mask;
	logic [2:0]     pend;
	logic [15:0]    exp_ps;
	logic [23:0]    reg_bank_base, vec_rd_addr, vec_rd_data, exp_vec_addr, vec_taken;
	logic [31:0]    exp_data[7];
	logic [2:0]     exp_bytes[7] = '{3'h4, 3'h1, 3'h1, 3'h1, 3'h1, 3'h2, 3'h2};
	pig_retire_t    retire;
	pig_cls_t       exec_cls;
	pig_cpu_state_t cpu_state;
	pig_irq_t       irq;
	pig_stack_wr_t  stack_wr;
	pig_branch_t    branch;
	integer         seed = 32'h53bf2d3f;
	int             n_mismatch = 0, compares = 0, n_push, n_bytes, n_ack = 0, n_branch = 0;

	pig_gate i_pig_gate (.core_clk, .rst_b, .ce, .retire, .exec_cls, .bank_pointer, .cpu_state,
		.reg_bank_base, .ccr_write_mask, .shared_bank_prefix, .flag_freeze_prefix,
		.bank_sel_code, .bank_sel_valid, .core_hold, .irq, .irq_ack, .stack_wr,
		.stack_wr_ready, .vec_rd_valid, .vec_rd_addr, .vec_rd_ready, .vec_rd_data, .branch);
	pig_irq_model i_pig_irq_model (.core_clk, .rst_b, .req_pulse, .req_level, .req_number,
		.irq_ack, .irq);

	// All pending prefix state in one word, to keep the checks short.
	assign pend = {shared_bank_prefix, flag_freeze_prefix, bank_sel_valid};

	////////////////////////////////////////////////////////////////////////////
	// Clock, and memory stalls that change at every falling edge.
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(negedge core_clk) begin
		stack_wr_ready = 1'($random(seed));
		vec_rd_ready = 1'($random(seed));
		vec_rd_data = 24'($random(seed));
	end

	task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("Mismatches %0d, comparisons %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// One finished instruction; spacing of two cycles keeps each pulse whole.
	task automatic retire_one(input pig_cls_t cls, input logic [1:0] code);
		@(negedge core_clk);
		retire = '{1'b1, cls, code};
		@(negedge core_clk);
		retire.valid = 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Reference model of the entry sequence, compared at every handshake.
	always @(posedge core_clk) begin
		if (rst_b && stack_wr.valid && stack_wr_ready) begin
			check("push sel", stack_wr.sel, n_push);
			check("push bytes", stack_wr.bytes, exp_bytes[n_push]);
			check("push data", stack_wr.data, exp_data[n_push]);
			n_bytes += stack_wr.bytes;
			n_push++;
		end
		if (rst_b && vec_rd_valid && vec_rd_ready) begin
			check("vector address", vec_rd_addr, exp_vec_addr);
			check("pushes before vector", n_push, 7);
			vec_taken = vec_rd_data;
		end
		if (rst_b && branch.valid) begin
			check("branch pc", branch.pc, vec_taken[15:0]);
			check("branch bank", branch.program_bank_reg, vec_taken[23:16]);
			check("branch status", branch.processor_status, exp_ps);
			check("bytes saved", n_bytes, 12);
			n_branch++;
		end
		if (rst_b && irq_ack) begin
			n_ack++;
		end
	end

	// Refused twice, held off by every blocking class, then taken.
	task automatic run_irq(input logic [2:0] lvl, input logic [7:0] num);
		pig_cls_t blk[6] = '{PIG_CLS_ILM_SET, PIG_CLS_CCR_ANDOR, PIG_CLS_POP_STATUS,
			PIG_CLS_SHARED_BANK, PIG_CLS_FLAG_FREEZE, PIG_CLS_BANK_SEL};
		int b0;
		int a0;
		cpu_state = {$random(seed), $random(seed), $random(seed)};
		cpu_state.processor_status[15:13] = lvl;
		cpu_state.processor_status[6] = 1'b1;
		req_level = lvl;
		req_number = num;
		req_pulse = 1'b1;
		@(negedge core_clk);
		req_pulse = 1'b0;
		retire_one(PIG_CLS_NORMAL, 2'h0);
		repeat (3) @(negedge core_clk);
		check("hold at equal level", core_hold, 1'b0);
		cpu_state.processor_status[15:13] = lvl + 3'h1;
		cpu_state.processor_status[6] = 1'b0;
		retire_one(PIG_CLS_NORMAL, 2'h0);
		repeat (3) @(negedge core_clk);
		check("hold while disabled", core_hold, 1'b0);
		cpu_state.processor_status[6] = 1'b1;
		exp_data = '{cpu_state.acc, 32'(cpu_state.direct_page_reg),
			32'(cpu_state.extra_data_bank), 32'(cpu_state.data_bank_reg),
			32'(cpu_state.program_bank_reg), 32'(cpu_state.pc),
			32'(cpu_state.processor_status)};
		exp_ps = cpu_state.processor_status;
		exp_ps[PIG_ILM_MSB:PIG_ILM_LSB] = lvl;
		exp_ps[PIG_S_BIT] = 1'b1;
		exp_vec_addr = PIG_VEC_TOP - 24'(num) * 24'h4;
		n_push = 0;
		n_bytes = 0;
		b0 = n_branch;
		a0 = n_ack;
		foreach (blk[i]) begin
			retire_one(blk[i], 2'($random(seed)));
			check("hold after blocking class", core_hold, 1'b0);
		end
		retire_one(PIG_CLS_NORMAL, 2'h0);
		for (int i = 0; i < 80 && n_branch == b0; i++) @(negedge core_clk);
		check("entries", n_branch, b0 + 1);
		check("acknowledges", n_ack, a0 + 1);
		repeat (2) @(negedge core_clk);
		check("hold after branch", core_hold, 1'b0);
	endtask

	////////////////////////////////////////////////////////////////////////////
	// Main sequence; prefixes are always consumed by a non-string instruction.
	initial begin
		pig_cls_t keep[7] = '{PIG_CLS_NORMAL, PIG_CLS_CCR_ANDOR, PIG_CLS_POP_STATUS,
			PIG_CLS_SOFT_INT, PIG_CLS_FAR_SOFT_INT, PIG_CLS_INT_RETURN, PIG_CLS_CTX_JUMP};
		logic [1:0] code;
		rst_b = 1'b0;
		ce = 1'b1;
		retire = '0;
		exec_cls = PIG_CLS_NORMAL;
		bank_pointer = 5'h3;
		cpu_state = '0;
		req_pulse = 1'b0;
		req_level = 3'h0;
		req_number = 8'h0;
		repeat (20) @(negedge core_clk);
		rst_b = 1'b1;
		#1;
		check("base after reset", reg_bank_base, 24'h0001b0);
		check("mask after reset", ccr_write_mask, PIG_CCR_ALL);
		check("prefixes after reset", pend, 3'h0);
		repeat (4) begin
			retire_one(PIG_CLS_SHARED_BANK, 2'h0);
			bank_pointer = 5'($random(seed));
			#1;
			check("common bank base", reg_bank_base, PIG_BANK_COMMON_BASE);
			retire_one(PIG_CLS_NORMAL, 2'h0);
			#1;
			check("own bank base", reg_bank_base, 24'h180 + 24'(bank_pointer) * 24'h10);
		end
		retire_one(PIG_CLS_FLAG_FREEZE, 2'h0);
		foreach (keep[i]) begin
			@(negedge core_clk);
			exec_cls = keep[i];
			exp_mask = (i == 0) ? (PIG_CCR_ALL & ~PIG_FLAG_TNZVC) : PIG_CCR_ALL;
			#1;
			check("flag write mask", ccr_write_mask, exp_mask);
		end
		@(negedge core_clk);
		exec_cls = PIG_CLS_NORMAL;
		retire_one(PIG_CLS_CCR_ANDOR, 2'h0);
		retire_one(PIG_CLS_POP_STATUS, 2'h0);
		retire_one(PIG_CLS_ILM_SET, 2'h0);
		check("freeze carried", flag_freeze_prefix, 1'b1);
		retire_one(PIG_CLS_SHARED_BANK, 2'h0);
		code = 2'($random(seed));
		retire_one(PIG_CLS_BANK_SEL, ~code);
		retire_one(PIG_CLS_BANK_SEL, code);
		check("last bank code", {bank_sel_valid, bank_sel_code}, {1'b1, code});
		check("prefixes held", {shared_bank_prefix, flag_freeze_prefix}, 2'h3);
		retire_one(PIG_CLS_NORMAL, 2'h0);
		check("prefixes cleared", pend, 3'h0);
		// A reset in mid-run must drop a pending prefix at once.
		retire_one(PIG_CLS_FLAG_FREEZE, 2'h0);
		check("freeze before reset", pend, 3'h2);
		rst_b = 1'b0;
		#1;
		check("prefixes in reset", pend, 3'h0);
		repeat (2) @(negedge core_clk);
		rst_b = 1'b1;
		repeat (4) run_irq(3'($unsigned($random(seed)) % 7), 8'($random(seed)));
		print_verdict();
	end

	// Watchdog: the whole sequence needs well under a thousand cycles.
	initial begin
		#50000;
		n_mismatch++;
		print_verdict();
	end
endmodule
